/* File: core/fetch_pointer_map.vh */
// constants for the fetch pointer and return stack block
// assumes inclusion by bare name from the design files
`ifndef FETCH_POINTER_MAP_VH
`define FETCH_POINTER_MAP_VH
`define PTR_W 21
`define RESET_VECTOR 21'h000000
`define HIGH_VECTOR 21'h000008
`define LOW_VECTOR 21'h000018
`define STEP 21'h000002
`define ZERO_ADDR 21'h000000
`define SP_W 5
`define SP_EMPTY 5'h00
`define SP_FULL 5'h1f
`define SP_ONE 5'h01
`define FULL_BIT 7
`define UNF_BIT 6
`define IMPL_END 21'h004000
`endif

/* File: core/program_counter_return_stack.v */
// fetch pointer, holding latches and return stack of the core
// assumes the sequencer issues at most one action per cycle, decoded by opcode
`timescale 1ns/1ps
`default_nettype none
`include "fetch_pointer_map.vh"
module program_counter_return_stack #(
   parameter DEPTH = 31,
   parameter [20:0] IMPL_SIZE = `IMPL_END
) (
   input wire CLK,
   input wire SYS_RST,
   input wire POR,
   input wire ADVANCE,
   input wire INT_HIGH_ACK,
   input wire INT_LOW_ACK,
   input wire CALL,
   input wire REL_CALL,
   input wire ABS_JUMP,
   input wire BRANCH,
   input wire [20:0] TARGET,
   input wire RET,
   input wire RET_LIT,
   input wire RET_INT,
   input wire LOW_BYTE_WR,
   input wire [7:0] LOW_BYTE_WDATA,
   input wire LOW_BYTE_RD,
   input wire HIGH_LATCH_WR,
   input wire UPPER_LATCH_WR,
   input wire [7:0] LATCH_WDATA,
   input wire SP_WR,
   input wire [7:0] SP_WDATA,
   input wire TOS_WR,
   input wire [20:0] TOS_WDATA,
   input wire STACK_FAULT_RESET_OPTION,
   input wire [15:0] MEM_RDATA,
   output wire [20:0] FETCH_ADDR,
   output wire [15:0] FETCH_WORD,
   output reg [7:0] FETCH_POINTER_LOW_BYTE,
   output reg [7:0] HIGH_BYTE_HOLDING_LATCH,
   output reg [7:0] UPPER_BYTE_HOLDING_LATCH,
   output reg [7:0] RETURN_STACK_POINTER,
   output reg [20:0] TOP_STACK_ENTRY,
   output wire STACK_FULL_FLAG,
   output wire STACK_UNDERFLOW_FLAG,
   output reg STACK_FAULT_RESET
);
   reg [20:0] ptr_q;
   reg [20:0] ptr_d;
   reg [7:0] hlat_q;
   reg [7:0] hlat_d;
   reg [4:0] ulat_q;
   reg [4:0] ulat_d;
   reg [4:0] sp_q;
   reg [4:0] sp_d;
   reg full_q;
   reg full_d;
   reg unf_q;
   reg unf_d;
   reg fault_d;
   reg we;
   reg [4:0] waddr;
   reg [20:0] wdata;
   wire [20:0] rdata;
   wire push;
   wire pop;
   wire [20:0] seq_next;

   function [20:0] align;
      input [20:0] a;
      begin
         align = {a[20:1], 1'b0};
      end
   endfunction

   assign push = CALL | REL_CALL | INT_HIGH_ACK | INT_LOW_ACK;
   assign pop = RET | RET_LIT | RET_INT;
   assign seq_next = ptr_q + `STEP;

   return_stack_ram #(
      .DEPTH(DEPTH),
      .W(`PTR_W)
   ) u_ram (
      .CLK(CLK),
      .WE(we),
      .WADDR(waddr),
      .WDATA(wdata),
      .RADDR(sp_q),
      .RDATA(rdata)
   );

   assign FETCH_ADDR = ptr_q;
   assign FETCH_WORD = (ptr_q < IMPL_SIZE) ? MEM_RDATA : 16'h0000;
   assign STACK_FULL_FLAG = full_q;
   assign STACK_UNDERFLOW_FLAG = unf_q;

   always @* begin
      ptr_d = ptr_q;
      hlat_d = hlat_q;
      ulat_d = ulat_q;
      sp_d = sp_q;
      full_d = full_q;
      unf_d = unf_q;
      fault_d = 1'b0;
      we = 1'b0;
      waddr = sp_q;
      wdata = seq_next;
      if (ADVANCE) begin
         ptr_d = seq_next;
      end
      if (HIGH_LATCH_WR) begin
         hlat_d = LATCH_WDATA;
      end
      if (UPPER_LATCH_WR) begin
         ulat_d = LATCH_WDATA[4:0];
      end
      if (LOW_BYTE_RD) begin
         hlat_d = ptr_q[15:8];
         ulat_d = ptr_q[20:16];
      end
      if (SP_WR) begin
         sp_d = SP_WDATA[4:0];
         // flags clear only, a zero written clears
         if (!SP_WDATA[`FULL_BIT]) begin
            full_d = 1'b0;
         end
         if (!SP_WDATA[`UNF_BIT]) begin
            unf_d = 1'b0;
         end
      end
      if (TOS_WR) begin
         we = 1'b1;
         waddr = sp_q;
         wdata = align(TOS_WDATA);
      end
      if (LOW_BYTE_WR) begin
         ptr_d = align({ulat_q, hlat_q, LOW_BYTE_WDATA});
      end
      if (ABS_JUMP || BRANCH) begin
         ptr_d = align(TARGET);
      end
      if (push) begin
         if (INT_HIGH_ACK) begin
            ptr_d = `HIGH_VECTOR;
         end else if (INT_LOW_ACK) begin
            ptr_d = `LOW_VECTOR;
         end else begin
            ptr_d = align(TARGET);
         end
         // return address is the word after the call
         wdata = seq_next;
         if (sp_q != `SP_FULL) begin
            sp_d = sp_q + `SP_ONE;
            waddr = sp_q + `SP_ONE;
            we = 1'b1;
            if (sp_q + `SP_ONE == `SP_FULL) begin
               full_d = 1'b1;
               fault_d = STACK_FAULT_RESET_OPTION;
            end
         end else begin
            full_d = 1'b1;
            fault_d = STACK_FAULT_RESET_OPTION;
         end
      end else if (pop) begin
         if (sp_q == `SP_EMPTY) begin
            ptr_d = `ZERO_ADDR;
            unf_d = 1'b1;
            fault_d = STACK_FAULT_RESET_OPTION;
         end else begin
            ptr_d = align(rdata);
            sp_d = sp_q - `SP_ONE;
         end
      end
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         ptr_q <= `RESET_VECTOR;
         sp_q <= `SP_EMPTY;
         hlat_q <= 8'h00;
         ulat_q <= 5'h00;
         STACK_FAULT_RESET <= 1'b0;
         if (POR) begin
            full_q <= 1'b0;
            unf_q <= 1'b0;
         end
      end else begin
         ptr_q <= ptr_d;
         hlat_q <= hlat_d;
         ulat_q <= ulat_d;
         sp_q <= sp_d;
         full_q <= full_d;
         unf_q <= unf_d;
         STACK_FAULT_RESET <= fault_d;
      end
   end

   // software view registers
   always @(posedge CLK) begin
      if (SYS_RST) begin
         FETCH_POINTER_LOW_BYTE <= 8'h00;
         HIGH_BYTE_HOLDING_LATCH <= 8'h00;
         UPPER_BYTE_HOLDING_LATCH <= 8'h00;
         RETURN_STACK_POINTER <= 8'h00;
         TOP_STACK_ENTRY <= `ZERO_ADDR;
      end else begin
         FETCH_POINTER_LOW_BYTE <= ptr_d[7:0];
         HIGH_BYTE_HOLDING_LATCH <= hlat_d;
         UPPER_BYTE_HOLDING_LATCH <= {3'h0, ulat_d};
         RETURN_STACK_POINTER <= {full_d, unf_d, 1'b0, sp_d};
         TOP_STACK_ENTRY <= rdata;
      end
   end
endmodule
`default_nettype wire

/* File: core/return_stack_ram.v */
// storage words of the return stack, entry 0 absent
// assumes one clock, write and read addressed by the stack pointer
`timescale 1ns/1ps
`default_nettype none
`include "fetch_pointer_map.vh"
module return_stack_ram #(
   parameter DEPTH = 31,
   parameter W = 21
) (
   input wire CLK,
   input wire WE,
   input wire [4:0] WADDR,
   input wire [W-1:0] WDATA,
   input wire [4:0] RADDR,
   output wire [W-1:0] RDATA
);
   reg [W-1:0] mem [1:DEPTH];
   // write lands only on real entries 1..depth
   always @(posedge CLK) begin
      if (WE && (WADDR != `SP_EMPTY)) begin
         mem[WADDR] <= WDATA;
      end
   end
   // pointer zero has no word behind it
   assign RDATA = (RADDR == `SP_EMPTY) ? {W{1'b0}} : mem[RADDR];
endmodule
`default_nettype wire

/* File: testbench/pcrs_sva.sv */
// port assertions for the fetch pointer block
// bound into the design; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module pcrs_sva #(parameter logic [20:0] IMPL_SIZE = 21'h004000) (
   input wire logic CLK, SYS_RST, POR, ADVANCE, INT_HIGH_ACK, INT_LOW_ACK, CALL, REL_CALL,
   input wire logic ABS_JUMP, BRANCH, RET, RET_LIT, RET_INT, LOW_BYTE_WR, SP_WR,
   input wire logic STACK_FULL_FLAG, STACK_UNDERFLOW_FLAG,
   input wire logic [20:0] TARGET, FETCH_ADDR,
   input wire logic [15:0] MEM_RDATA, FETCH_WORD
);
   wire pp = CALL | REL_CALL | INT_HIGH_ACK | INT_LOW_ACK | RET | RET_LIT | RET_INT;
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   jump_load_a: assert property ((ABS_JUMP | BRANCH) & !pp |=>
      FETCH_ADDR == ($past(TARGET) & 21'h1ffffe)) else $error("jump");
   step_two_a: assert property (ADVANCE & !pp & !ABS_JUMP & !BRANCH & !LOW_BYTE_WR |=>
      FETCH_ADDR == $past(FETCH_ADDR) + 21'h2) else $error("step");
   int_vector_a: assert property ((INT_HIGH_ACK ^ INT_LOW_ACK) & !CALL & !REL_CALL |=>
      FETCH_ADDR == ($past(INT_HIGH_ACK) ? 21'h8 : 21'h18)) else $error("vector");
   even_addr_a: assert property (!FETCH_ADDR[0]) else $error("odd address");
   zero_word_a: assert property (
      FETCH_WORD == (FETCH_ADDR >= IMPL_SIZE ? 16'h0 : MEM_RDATA)) else $error("word");
   reset_vec_a: assert property (disable iff (1'b0) SYS_RST |=> FETCH_ADDR == 21'h0)
      else $error("reset vector");
   unf_keep_a: assert property (disable iff (SYS_RST & POR)
      STACK_UNDERFLOW_FLAG & !SP_WR |=> STACK_UNDERFLOW_FLAG) else $error("underflow lost");
   full_keep_a: assert property (disable iff (SYS_RST & POR)
      STACK_FULL_FLAG & !SP_WR |=> STACK_FULL_FLAG) else $error("full lost");
endmodule
`default_nettype wire

/* File: testbench/prog_mem_model.sv */
// program memory on the far side of the fetch port
// combinational read, word derived from the address
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
   input wire logic [20:0] ADDR,
   output logic [15:0] DATA
);
   assign DATA = ADDR[16:1] ^ 16'ha5c3;
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// bench for the fetch pointer block, compared with an integer model
// one request per operation, inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [20:0] IMPL = 21'h000100;
   logic CLK = 0, SYS_RST = 1, POR = 1, STACK_FAULT_RESET_OPTION = 0;
   logic [15:0] rq = 0;
   logic [20:0] TARGET = 0, TOS_WDATA = 0;
   logic [7:0] LOW_BYTE_WDATA = 0, LATCH_WDATA = 0, SP_WDATA = 0;
   wire ADVANCE, INT_HIGH_ACK, INT_LOW_ACK, CALL, REL_CALL, ABS_JUMP, BRANCH, RET, RET_LIT, RET_INT;
   wire LOW_BYTE_WR, LOW_BYTE_RD, HIGH_LATCH_WR, UPPER_LATCH_WR, SP_WR, TOS_WR, STACK_FAULT_RESET;
   wire STACK_FULL_FLAG, STACK_UNDERFLOW_FLAG;
   wire [20:0] FETCH_ADDR, TOP_STACK_ENTRY;
   wire [15:0] MEM_RDATA, FETCH_WORD;
   wire [7:0] FETCH_POINTER_LOW_BYTE, HIGH_BYTE_HOLDING_LATCH, UPPER_BYTE_HOLDING_LATCH;
   wire [7:0] RETURN_STACK_POINTER;
   integer seed = 32'h8a0c50ee;
   int miscompares = 0, comparisons = 0, pc = 0, sp = 0, hl = 0, ul = 0, fl = 0, un = 0, n;
   int stk[32];
   int faults = 0, ef = 0;
   assign {TOS_WR, SP_WR, UPPER_LATCH_WR, HIGH_LATCH_WR, LOW_BYTE_RD, LOW_BYTE_WR, RET_INT, RET_LIT,
      RET, BRANCH, ABS_JUMP, REL_CALL, CALL, INT_LOW_ACK, INT_HIGH_ACK, ADVANCE} = rq;
   program_counter_return_stack #(.IMPL_SIZE(IMPL)) dut_u (.*);
   prog_mem_model mem_u (.ADDR(FETCH_ADDR), .DATA(MEM_RDATA));
   initial forever #25 CLK = ~CLK;
   // fault pulse stands one cycle, so one falling edge sees it
   always @(negedge CLK) if (STACK_FAULT_RESET === 1'b1) faults++;
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("Error t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic conclude;
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check;
      repeat (3) @(posedge CLK);
      @(negedge CLK);
      cmp(FETCH_ADDR, pc);
      cmp(FETCH_WORD, pc < IMPL ? ((pc >> 1) & 'hffff) ^ 'ha5c3 : 0);
      cmp(faults, ef);
      cmp({HIGH_BYTE_HOLDING_LATCH, UPPER_BYTE_HOLDING_LATCH, FETCH_POINTER_LOW_BYTE},
         {hl[7:0], ul[7:0], pc[7:0]});
      cmp({RETURN_STACK_POINTER, STACK_FULL_FLAG, STACK_UNDERFLOW_FLAG},
         {fl[0], un[0], 1'b0, sp[4:0], fl[0], un[0]});
      if (sp != 0) cmp(TOP_STACK_ENTRY, stk[sp]);
      else cmp(TOP_STACK_ENTRY, 0);
   endtask
   task automatic rst(input logic por);
      @(negedge CLK);
      SYS_RST = 1;
      POR = por;
      repeat (2) @(posedge CLK);
      @(negedge CLK);
      SYS_RST = 0;
      POR = 0;
      {pc, sp, hl, ul} = 0;
      if (por) {fl, un} = 0;
      check();
   endtask
   task automatic op(input int k);
      @(negedge CLK);
      {TARGET, TOS_WDATA, LOW_BYTE_WDATA, LATCH_WDATA, SP_WDATA} = {$random(seed), $random(seed)};
      TOS_WDATA[0] = 1'b0;
      STACK_FAULT_RESET_OPTION = $random(seed);
      rq = 16'h1 << k;
      @(negedge CLK);
      rq = 0;
      case (k)
         0: pc = (pc + 2) & 'h1fffff;
         1, 2, 3, 4: begin
            ef += STACK_FAULT_RESET_OPTION && sp >= 30;
            if (sp < 31) begin
               sp++;
               stk[sp] = (pc + 2) & 'h1fffff;
            end
            fl |= sp == 31;
            pc = k == 1 ? 8 : k == 2 ? 'h18 : TARGET & 'h1ffffe;
         end
         5, 6: pc = TARGET & 'h1ffffe;
         7, 8, 9: begin
            ef += STACK_FAULT_RESET_OPTION && sp == 0;
            pc = sp == 0 ? 0 : stk[sp];
            un |= sp == 0;
            sp = sp == 0 ? 0 : sp - 1;
         end
         10: pc = (ul & 'h1f) << 16 | hl << 8 | LOW_BYTE_WDATA & 'hfe;
         11: begin
            hl = pc >> 8 & 'hff;
            ul = pc >> 16;
         end
         12: hl = LATCH_WDATA;
         13: ul = LATCH_WDATA & 'h1f;
         14: begin
            sp = SP_WDATA & 'h1f;
            fl &= SP_WDATA[7];
            un &= SP_WDATA[6];
         end
         15: if (sp != 0) stk[sp] = TOS_WDATA;
      endcase
      check();
   endtask
   initial begin
      rst(1);
      for (n = 0; n < 33; n++) op(3);
      rst(0);
      op(7);
      for (n = 0; n < 400; n++) op($unsigned($random(seed)) % 16);
      rst(1);
      conclude();
   end
   initial begin
      #400000;
      miscompares++;
      conclude();
   end
endmodule
bind program_counter_return_stack pcrs_sva #(.IMPL_SIZE(IMPL_SIZE)) sva_u (.*);
`default_nettype wire
